/* File: rtl/dtdec_pkg.sv */
// Constants and types for the data-transfer decode and timing block.
// Assumes a byte stream from the bus interface unit, one byte a clock.
package dtdec_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_SEG_LD = 8'h8e;
  localparam logic [7:0] OP_SEG_ST = 8'h8c;
  localparam logic [7:0] OP_LDPTR_DS = 8'hc5;
  localparam logic [7:0] OP_LDPTR_ES = 8'hc4;
  localparam logic [7:0] OP_TBL_XLT = 8'hd7;
  localparam logic [7:0] OP_LD_EA = 8'h8d;
  localparam logic [7:0] OP_FLG_TO_AH = 8'h9f;
  localparam logic [7:0] OP_AH_TO_FLG = 8'h9e;
  localparam logic [6:0] OP_MOV_TO_RM = 7'h44;
  localparam logic [6:0] OP_MOV_FROM_RM = 7'h45;
  localparam logic [6:0] OP_MOV_ACC_LD = 7'h50;
  localparam logic [6:0] OP_MOV_ACC_ST = 7'h51;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // ****************************************
  // Minimum clocks (wide bus / narrow bus)
  // ****************************************
  localparam logic [5:0] CLK_REG = 6'h02;
  localparam logic [5:0] CLK_MOV_TO_MEM = 6'h0c;
  localparam logic [5:0] CLK_MOV_FROM_MEM = 6'h09;
  localparam logic [5:0] CLK_ACC_LD = 6'h08;
  localparam logic [5:0] CLK_ACC_ST = 6'h09;
  localparam logic [5:0] CLK_SEG_LD_W = 6'h09;
  localparam logic [5:0] CLK_SEG_LD_N = 6'h0d;
  localparam logic [5:0] CLK_SEG_ST_W = 6'h0b;
  localparam logic [5:0] CLK_SEG_ST_N = 6'h0f;
  localparam logic [5:0] CLK_LDPTR_W = 6'h12;
  localparam logic [5:0] CLK_LDPTR_N = 6'h1a;
  localparam logic [5:0] CLK_XLT_W = 6'h0b;
  localparam logic [5:0] CLK_XLT_N = 6'h0f;
  localparam logic [5:0] CLK_LD_EA = 6'h06;
  localparam logic [5:0] CLK_FLG_TO_AH = 6'h02;
  localparam logic [5:0] CLK_AH_TO_FLG = 6'h03;
  localparam logic [5:0] CLK_WORD_PEN = 6'h04;
  localparam logic [1:0] HS_EXTRA_MAX = 2'h2;

  // ****************************************
  // Prefetch queue depths
  // ****************************************
  localparam int QUEUE_DEPTH = 6;
  localparam logic [2:0] DEPTH_WIDE = 3'h6;
  localparam logic [2:0] DEPTH_NARROW = 3'h4;

  typedef enum logic [3:0] {
    DT_NONE = 4'h0,
    DT_MOV_TO_RM = 4'h1,
    DT_MOV_FROM_RM = 4'h2,
    DT_ACC_LD = 4'h3,
    DT_ACC_ST = 4'h4,
    DT_SEG_LD = 4'h5,
    DT_SEG_ST = 4'h6,
    DT_LDPTR_DS = 4'h7,
    DT_LDPTR_ES = 4'h8,
    DT_TBL_XLT = 4'h9,
    DT_LD_EA = 4'ha,
    DT_FLG_TO_AH = 4'hb,
    DT_AH_TO_FLG = 4'hc
  } dtdec_class_t;

  typedef enum logic [1:0] {
    ST_OPC = 2'h0,
    ST_MODRM = 2'h1,
    ST_DISP = 2'h2,
    ST_EXEC = 2'h3
  } dtdec_state_t;

endpackage

/* File: rtl/dtdec_queue.sv */
// Instruction prefetch queue, byte wide.
// Filled by the bus interface unit, drained by the decoder.
`timescale 1ns/1ps
module dtdec_queue
  import dtdec_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic [2:0] limit_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [7:0] in_byte_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [7:0] out_byte_o,
  input wire logic out_take_i
);
  import dtdec_pkg::*;

  logic [7:0] mem [QUEUE_DEPTH];
  logic [2:0] rd_ptr, wr_ptr, count;
  logic [2:0] next_rd_ptr, next_wr_ptr, next_count;
  logic push, pop;

  assign in_ready_o = (count < limit_i) && !flush_i;
  assign out_valid_o = (count != 3'h0);
  assign out_byte_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_take_i && out_valid_o;

  always_comb
  begin
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    if (flush_i)
    begin
      next_rd_ptr = 3'h0;
      next_wr_ptr = 3'h0;
      next_count = 3'h0;
    end
    else
    begin
      if (push)
        next_wr_ptr = (wr_ptr == 3'(QUEUE_DEPTH - 1)) ? 3'h0 : wr_ptr + 3'h1;
      if (pop)
        next_rd_ptr = (rd_ptr == 3'(QUEUE_DEPTH - 1)) ? 3'h0 : rd_ptr + 3'h1;
      if (push && !pop)
        next_count = count + 3'h1;
      else if (pop && !push)
        next_count = count - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_ptr <= 3'h0;
      wr_ptr <= 3'h0;
      count <= 3'h0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_byte_i;
  end

endmodule // dtdec_queue

/* File: rtl/dtdec_top.sv */
// Data-transfer group decoder with minimum execution time per instruction.
// Assumes bus interface unit pushes bytes in program order; flush on jump.
//
// Overview of operation
// [RULE1] 8E plus mode byte loads segment register; 2/9 wide, 2/13 narrow.
// [RULE2] 8C plus mode byte stores segment register; 2/11 wide, 2/15 narrow.
// [RULE3] C5 loads far pointer with data segment; no register mode; 18/26.
// [RULE4] C4 loads far pointer with extra segment; no register mode; 18/26.
// [RULE5] D7 translates low accumulator byte through table; 11 wide, 15 narrow.
// [RULE6] 8D writes effective address to register in 6 clocks on both.
// [RULE7] 9F copies low flags to accumulator high byte in 2 clocks.
// [RULE8] 9E copies accumulator high byte to low flags in 3 clocks.
// [RULE9] Narrow bus adds 4 clocks per memory transfer for marked word ops.
// [RULE10] Memory instructions may take one or two extra handshake clocks.
// [RULE11] Jump and call counts include the first opcode fetch at target.
// [RULE12] Wide-bus variant prefetch queue is six bytes deep.
// [RULE13] Narrow-bus variant prefetch queue is four bytes deep.
// [RULE14] Minimum counts assume bytes queued, no waits, even word addresses.
// [RULE15] Trailing width bit zero selects byte, one selects word operand.
`timescale 1ns/1ps
module dtdec_top
  import dtdec_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Variant and control
  input wire logic narrow_bus_i,
  input wire logic flush_i,
  input wire logic [1:0] hs_extra_i,
  // Bus interface unit fill port
  input wire logic fill_valid_i,
  input wire logic [7:0] fill_byte_i,
  output logic fill_ready_o,
  // Decode results
  output logic busy_o,
  output logic done_o,
  output logic decode_err_o,
  output dtdec_pkg::dtdec_class_t class_o,
  output logic word_op_o,
  output logic mem_op_o,
  output logic [5:0] clocks_o
);
  import dtdec_pkg::*;

  // ****************************************
  // Prefetch queue
  // ****************************************
  logic q_valid, q_take;
  logic [7:0] q_byte;
  logic [2:0] q_limit;

  assign q_limit = narrow_bus_i ? DEPTH_NARROW : DEPTH_WIDE; // RULE12 RULE13

  dtdec_queue u_queue (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .limit_i(q_limit),
    .flush_i(flush_i),
    .in_valid_i(fill_valid_i),
    .in_byte_i(fill_byte_i),
    .in_ready_o(fill_ready_o),
    .out_valid_o(q_valid),
    .out_byte_o(q_byte),
    .out_take_i(q_take)
  );

  // ****************************************
  // Clock count table
  // ****************************************
  function automatic logic [5:0] min_clocks(
    input dtdec_class_t c,
    input logic narrow,
    input logic mem,
    input logic word,
    input logic [1:0] hs
  );
    logic [5:0] t;
    logic marked;
    t = 6'h00;
    marked = 1'b0;
    case (c)
      DT_MOV_TO_RM:
      begin
        t = mem ? CLK_MOV_TO_MEM : CLK_REG;
        marked = 1'b1;
      end
      DT_MOV_FROM_RM:
      begin
        t = mem ? CLK_MOV_FROM_MEM : CLK_REG;
        marked = 1'b1;
      end
      DT_ACC_LD:
      begin
        t = CLK_ACC_LD;
        marked = 1'b1;
      end
      DT_ACC_ST:
      begin
        t = CLK_ACC_ST;
        marked = 1'b1;
      end
      DT_SEG_LD:
        t = !mem ? CLK_REG : (narrow ? CLK_SEG_LD_N : CLK_SEG_LD_W); // RULE1
      DT_SEG_ST:
        t = !mem ? CLK_REG : (narrow ? CLK_SEG_ST_N : CLK_SEG_ST_W); // RULE2
      DT_LDPTR_DS, DT_LDPTR_ES:
        t = narrow ? CLK_LDPTR_N : CLK_LDPTR_W; // RULE3 RULE4
      DT_TBL_XLT:
        t = narrow ? CLK_XLT_N : CLK_XLT_W; // RULE5
      DT_LD_EA:
        t = CLK_LD_EA; // RULE6
      DT_FLG_TO_AH:
        t = CLK_FLG_TO_AH; // RULE7
      DT_AH_TO_FLG:
        t = CLK_AH_TO_FLG; // RULE8
      default:
        t = 6'h00;
    endcase
    if (narrow && marked && mem && word)
      t = t + CLK_WORD_PEN; // RULE9
    if (mem && c != DT_LD_EA)
      t = t + {4'h0, (hs > HS_EXTRA_MAX) ? HS_EXTRA_MAX : hs}; // RULE10
    return t;
  endfunction

  // ****************************************
  // Decode state
  // ****************************************
  dtdec_state_t state, next_state;
  dtdec_class_t cls, next_cls;
  logic wrd, next_wrd;
  logic mem, next_mem;
  logic [1:0] disp_left, next_disp_left;
  logic [5:0] cnt, next_cnt;
  logic done, next_done;
  logic err, next_err;
  logic [5:0] clocks, next_clocks;

  dtdec_class_t op_cls;
  logic op_word, op_modrm, op_addr;
  logic [1:0] md;
  logic [2:0] rm;
  logic md_mem;
  logic [1:0] md_disp;
  logic [5:0] t_sel;

  // Opcode classification straight from the queue head
  always_comb
  begin
    op_cls = DT_NONE;
    op_word = q_byte[0]; // RULE15
    op_modrm = 1'b1;
    op_addr = 1'b0;
    case (q_byte)
      OP_SEG_LD: op_cls = DT_SEG_LD; // RULE1
      OP_SEG_ST: op_cls = DT_SEG_ST; // RULE2
      OP_LDPTR_DS: op_cls = DT_LDPTR_DS; // RULE3
      OP_LDPTR_ES: op_cls = DT_LDPTR_ES; // RULE4
      OP_LD_EA: op_cls = DT_LD_EA; // RULE6
      OP_TBL_XLT: op_cls = DT_TBL_XLT; // RULE5
      OP_FLG_TO_AH: op_cls = DT_FLG_TO_AH; // RULE7
      OP_AH_TO_FLG: op_cls = DT_AH_TO_FLG; // RULE8
      default:
      begin
        case (q_byte[7:1])
          OP_MOV_TO_RM: op_cls = DT_MOV_TO_RM;
          OP_MOV_FROM_RM: op_cls = DT_MOV_FROM_RM;
          OP_MOV_ACC_LD: op_cls = DT_ACC_LD;
          OP_MOV_ACC_ST: op_cls = DT_ACC_ST;
          default: op_cls = DT_NONE;
        endcase
      end
    endcase
    case (op_cls)
      DT_SEG_LD, DT_SEG_ST, DT_LDPTR_DS, DT_LDPTR_ES, DT_LD_EA, DT_TBL_XLT,
      DT_FLG_TO_AH, DT_AH_TO_FLG:
        op_word = 1'b1;
      default: op_word = q_byte[0]; // RULE15
    endcase
    case (op_cls)
      DT_TBL_XLT, DT_FLG_TO_AH, DT_AH_TO_FLG, DT_NONE: op_modrm = 1'b0;
      DT_ACC_LD, DT_ACC_ST:
      begin
        op_modrm = 1'b0;
        op_addr = 1'b1;
      end
      default: op_modrm = 1'b1;
    endcase
  end

  // Mode byte fields and displacement length
  always_comb
  begin
    md = q_byte[7:6];
    rm = q_byte[2:0];
    md_mem = (md != MOD_REG);
    if (md == 2'h1)
      md_disp = 2'h1;
    else if (md == 2'h2 || (md == 2'h0 && rm == RM_DIRECT))
      md_disp = 2'h2;
    else
      md_disp = 2'h0;
  end

  always_comb
  begin
    next_state = state;
    next_cls = cls;
    next_wrd = wrd;
    next_mem = mem;
    next_disp_left = disp_left;
    next_cnt = cnt;
    next_done = 1'b0;
    next_err = 1'b0;
    next_clocks = clocks;
    q_take = 1'b0;
    t_sel = 6'h00;
    case (state)
      ST_OPC:
      begin
        if (q_valid) // RULE14
        begin
          q_take = 1'b1;
          next_cls = op_cls;
          next_wrd = op_word;
          next_mem = op_addr || op_cls == DT_TBL_XLT;
          next_disp_left = op_addr ? 2'h2 : 2'h0;
          t_sel = min_clocks(op_cls, narrow_bus_i,
                             op_addr || op_cls == DT_TBL_XLT, op_word,
                             hs_extra_i);
          next_cnt = t_sel;
          if (op_cls == DT_NONE)
            next_err = 1'b1;
          else if (op_modrm)
            next_state = ST_MODRM;
          else if (op_addr)
            next_state = ST_DISP;
          else
          begin
            next_clocks = t_sel;
            next_state = ST_EXEC;
          end
        end
      end
      ST_MODRM:
      begin
        if (q_valid) // RULE14
        begin
          q_take = 1'b1;
          next_mem = md_mem;
          next_disp_left = md_disp;
          t_sel = min_clocks(cls, narrow_bus_i, md_mem, wrd, hs_extra_i);
          next_cnt = t_sel;
          if ((cls == DT_LDPTR_DS || cls == DT_LDPTR_ES) && !md_mem)
          begin
            next_err = 1'b1; // RULE3 RULE4
            next_state = ST_OPC;
          end
          else if (md_disp != 2'h0)
            next_state = ST_DISP;
          else
          begin
            next_clocks = t_sel;
            next_state = ST_EXEC;
          end
        end
      end
      ST_DISP:
      begin
        if (q_valid) // RULE14
        begin
          q_take = 1'b1;
          next_disp_left = disp_left - 2'h1;
          if (disp_left == 2'h1)
          begin
            next_clocks = cnt;
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC:
      begin
        next_cnt = cnt - 6'h01;
        if (cnt <= 6'h01)
        begin
          next_cnt = 6'h00;
          next_done = 1'b1;
          next_state = ST_OPC;
        end
      end
      default: next_state = ST_OPC;
    endcase
    // Jump target restart: next opcode fetch counts from here
    if (flush_i) // RULE11
    begin
      next_state = ST_OPC;
      next_cnt = 6'h00;
      next_done = 1'b0;
      next_err = 1'b0;
      q_take = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= ST_OPC;
      cls <= DT_NONE;
      wrd <= 1'b0;
      mem <= 1'b0;
      disp_left <= 2'h0;
      cnt <= 6'h00;
      done <= 1'b0;
      err <= 1'b0;
      clocks <= 6'h00;
    end
    else
    begin
      state <= next_state;
      cls <= next_cls;
      wrd <= next_wrd;
      mem <= next_mem;
      disp_left <= next_disp_left;
      cnt <= next_cnt;
      done <= next_done;
      err <= next_err;
      clocks <= next_clocks;
    end
  end

  assign busy_o = (state != ST_OPC);
  assign done_o = done;
  assign decode_err_o = err;
  assign class_o = cls;
  assign word_op_o = wrd;
  assign mem_op_o = mem;
  assign clocks_o = clocks;

endmodule // dtdec_top

/* File: verif/dtdec_biu_model.sv */
// Bus interface unit model feeding the prefetch queue.
// Assumes the bench pushes program bytes into q.
`timescale 1ns/1ps
module dtdec_biu_model
(
  // Clock
  input wire logic clk_i,
  // Fill handshake
  input wire logic fill_ready_i,
  input wire logic stall_i,
  output logic fill_valid_o,
  output logic [7:0] fill_byte_o
);
  logic [7:0] q [$];
  logic taken;
  // Remember whether the offered byte went in at this edge
  always @(posedge clk_i)
  begin
    taken <= fill_valid_o && fill_ready_i && q.size() > 0;
    if (fill_valid_o && fill_ready_i && q.size() > 0)
      void'(q.pop_front());
  end
  // Hold offered byte until taken; idle data toggles
  always @(negedge clk_i)
  begin
    if (q.size() > 0 && ((fill_valid_o && !taken) || !stall_i))
    begin
      fill_valid_o = 1'b1;
      fill_byte_o = q[0];
    end
    else
    begin
      fill_valid_o = 1'b0;
      fill_byte_o = ~fill_byte_o;
    end
  end
endmodule // dtdec_biu_model

/* File: verif/dtdec_top_monitor.sv */
// Port checker for the data-transfer decoder.
// Assumes it is bound onto dtdec_top.
`timescale 1ns/1ps
module dtdec_top_monitor
  import dtdec_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic narrow_bus_i,
  input wire logic flush_i,
  input wire logic fill_ready_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire dtdec_pkg::dtdec_class_t class_o,
  input wire logic mem_op_o,
  input wire logic word_op_o,
  input wire logic [5:0] clocks_o
);
  import dtdec_pkg::*;

  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_fin(dtdec_class_t c);
    done_o && class_o == c;
  endsequence
  sequence s_fin_reg(dtdec_class_t c);
    done_o && class_o == c && !mem_op_o;
  endsequence
  sequence s_fin_mem(dtdec_class_t c);
    done_o && class_o == c && mem_op_o;
  endsequence
  sequence s_flags_to_acc_high_go;
    $rose(busy_o) && class_o == DT_FLG_TO_AH;
  endsequence

  a_seg_reg_time: assert property (
    s_fin_reg(DT_SEG_LD) |-> clocks_o == 6'h02)
    else $error("segment load count wrong");
  a_seg_ld_mem: assert property (
    s_fin_mem(DT_SEG_LD)
    |-> clocks_o - (narrow_bus_i ? 6'h0d : 6'h09) <= 6'h02)
    else $error("segment load memory count wrong");
  a_seg_st_time: assert property (
    s_fin_mem(DT_SEG_ST)
    |-> clocks_o - (narrow_bus_i ? 6'h0f : 6'h0b) <= 6'h02)
    else $error("segment store count wrong");
  a_seg_st_reg: assert property (
    s_fin_reg(DT_SEG_ST) |-> clocks_o == 6'h02)
    else $error("segment store register count wrong");
  a_word_pen: assert property (
    done_o && class_o == DT_ACC_LD && word_op_o
    |-> clocks_o - (narrow_bus_i ? 6'h0c : 6'h08) <= 6'h02)
    else $error("word penalty count wrong");
  a_ptr_load_time: assert property (
    done_o && class_o inside {DT_LDPTR_DS, DT_LDPTR_ES}
    |-> clocks_o - (narrow_bus_i ? 6'h1a : 6'h12) <= 6'h02)
    else $error("pointer load count wrong");
  a_table_translate_time: assert property (
    s_fin(DT_TBL_XLT)
    |-> clocks_o - (narrow_bus_i ? 6'h0f : 6'h0b) <= 6'h02)
    else $error("table translate count wrong");
  a_lea_time: assert property (s_fin(DT_LD_EA) |-> clocks_o == 6'h06)
    else $error("effective address count wrong");
  a_flags_to_acc_high_time: assert property (s_fin(DT_FLG_TO_AH) |-> clocks_o == 6'h02)
    else $error("flags to acc count wrong");
  a_acc_high_to_flags_time: assert property (s_fin(DT_AH_TO_FLG) |-> clocks_o == 6'h03)
    else $error("acc to flags count wrong");
  a_flags_to_acc_high_done_lat: assert property (s_flags_to_acc_high_go |-> !done_o [*2] ##1 done_o)
    else $error("flags to acc finish late");
  a_flush_blocks: assert property (flush_i |-> !fill_ready_o)
    else $error("fill accepted during flush");
endmodule // dtdec_top_monitor

bind dtdec_top dtdec_top_monitor u_mon (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .narrow_bus_i(narrow_bus_i),
  .flush_i(flush_i),
  .fill_ready_o(fill_ready_o),
  .busy_o(busy_o),
  .done_o(done_o),
  .class_o(class_o),
  .mem_op_o(mem_op_o),
  .word_op_o(word_op_o),
  .clocks_o(clocks_o)
);

/* File: verif/tb_data_transfer_decode_timing.sv */
// Self-checking bench for the data-transfer decoder.
// Assumes dtdec_top, the bus interface model and the bound checker.
`timescale 1ns/1ps
module tb_data_transfer_decode_timing;
  import dtdec_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic narrow;
  logic flush;
  logic [1:0] hs;
  logic stall = 1'b0;
  logic stall_en;
  logic fill_valid, fill_ready, busy, done, err, word_op, mem_op;
  logic [7:0] fill_byte;
  logic [5:0] clocks;
  dtdec_class_t cls;
  int errors = 0;
  int n_compared = 0;
  logic [7:0] ops [16] = '{8'h8e, 8'h8c, 8'hc5, 8'hc4, 8'hd7, 8'h8d,
    8'h9f, 8'h9e, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'ha0, 8'ha1, 8'ha2, 8'ha3};

  always #2 clk = ~clk;
  always @(negedge clk) stall <= stall_en && ($urandom % 3 == 0);

  dtdec_top uut (.clk_i(clk), .rst_b_i(rst_b), .narrow_bus_i(narrow),
    .flush_i(flush), .hs_extra_i(hs), .fill_valid_i(fill_valid),
    .fill_byte_i(fill_byte), .fill_ready_o(fill_ready), .busy_o(busy),
    .done_o(done), .decode_err_o(err), .class_o(cls), .word_op_o(word_op),
    .mem_op_o(mem_op), .clocks_o(clocks));
  dtdec_biu_model biu (.clk_i(clk), .fill_ready_i(fill_ready),
    .stall_i(stall), .fill_valid_o(fill_valid), .fill_byte_o(fill_byte));

  // ****
  // Checking helpers
  // ****
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic is_mem(input logic [7:0] op, input logic [7:0] m);
    if (op inside {8'hc4, 8'hc5, 8'hd7} || op[7:2] == 6'h28) return 1'b1;
    if (op[7:2] inside {6'h22, 6'h23} && op != 8'h8d) return m[7:6] != 2'h3;
    return 1'b0;
  endfunction

  function automatic logic [5:0] exp_clk(input logic [7:0] op,
    input logic [7:0] m, input logic [1:0] h);
    logic [5:0] c;
    logic mm;
    mm = is_mem(op, m);
    case (op)
      8'h8e: c = !mm ? 6'h02 : narrow ? 6'h0d : 6'h09;
      8'h8c: c = !mm ? 6'h02 : narrow ? 6'h0f : 6'h0b;
      8'hc4, 8'hc5: c = narrow ? 6'h1a : 6'h12;
      8'hd7: c = narrow ? 6'h0f : 6'h0b;
      8'h8d: c = 6'h06;
      8'h9f: c = 6'h02;
      8'h9e: c = 6'h03;
      8'h88, 8'h89: c = mm ? 6'h0c : 6'h02;
      8'h8a, 8'h8b: c = mm ? 6'h09 : 6'h02;
      8'ha0, 8'ha1: c = 6'h08;
      default: c = 6'h09;
    endcase
    if (narrow && mm && op[0] && op[7:2] inside {6'h22, 6'h28}) c = c + 6'h04;
    if (mm) c = c + (h > 2'h2 ? 6'h02 : {4'h0, h});
    return c;
  endfunction

  function automatic dtdec_class_t exp_cls(input logic [7:0] op);
    case (op)
      8'h8e: return DT_SEG_LD;
      8'h8c: return DT_SEG_ST;
      8'hc5: return DT_LDPTR_DS;
      8'hc4: return DT_LDPTR_ES;
      8'hd7: return DT_TBL_XLT;
      8'h8d: return DT_LD_EA;
      8'h9f: return DT_FLG_TO_AH;
      8'h9e: return DT_AH_TO_FLG;
      8'h88, 8'h89: return DT_MOV_TO_RM;
      8'h8a, 8'h8b: return DT_MOV_FROM_RM;
      8'ha0, 8'ha1: return DT_ACC_LD;
      default: return DT_ACC_ST;
    endcase
  endfunction

  task automatic wait_for(input logic want_err);
    for (int k = 0; k < 300; k++)
    begin
      @(negedge clk);
      if ((want_err ? err : done) === 1'b1) break;
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] m,
    input logic [1:0] h);
    int n;
    hs = h;
    n = 0;
    biu.q.push_back(op);
    if (op[7:2] == 6'h28) n = 2;
    else if (!(op inside {8'hd7, 8'h9e, 8'h9f}))
    begin
      biu.q.push_back(m);
      if (m[7:6] == 2'h1) n = 1;
      else if (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) n = 2;
    end
    repeat (n) biu.q.push_back(8'($urandom));
    wait_for(1'b0);
    check({7'h0, done}, 8'h01);
    check({4'h0, cls}, {4'h0, exp_cls(op)});
    check({2'h0, clocks}, {2'h0, exp_clk(op, m, h)});
    if (op[7:2] inside {6'h22, 6'h28})
      check({7'h0, word_op}, {7'h0, op[0]});
    if (op[7:2] inside {6'h22, 6'h23, 6'h28, 6'h31} && op != 8'h8d)
      check({7'h0, mem_op}, {7'h0, is_mem(op, m)});
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    logic [7:0] m;
    int i;
    narrow = 1'b0;
    flush = 1'b0;
    hs = 2'h0;
    stall_en = 1'b0;
    void'($urandom(40520));
    for (int nb = 0; nb < 2; nb++)
    begin
      biu.q.delete();
      rst_b = 1'b0;
      narrow = nb[0];
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      foreach (ops[j])
      begin
        run(ops[j], ops[j][7:1] == 7'h62 ? 8'h06 : 8'hc0, 2'h0);
        run(ops[j], 8'h86, 2'h3);
      end
      $display("opcode table done, narrow %0d", nb);
      biu.q.push_back(8'h00);
      wait_for(1'b1);
      check({7'h0, err}, 8'h01);
      biu.q.push_back(8'hc5);
      biu.q.push_back(8'hc0);
      wait_for(1'b1);
      check({7'h0, err}, 8'h01);
      biu.q.push_back(8'hc5);
      biu.q.push_back(8'h00);
      repeat (8) biu.q.push_back(8'h9f);
      repeat (12) @(negedge clk);
      check(8'(biu.q.size()), nb ? 8'h04 : 8'h02);
      check({7'h0, fill_ready}, 8'h00);
      repeat (9) wait_for(1'b0);
      check({7'h0, done}, 8'h01);
      check({4'h0, cls}, {4'h0, DT_FLG_TO_AH});
      biu.q.push_back(8'h8e);
      repeat (3) @(negedge clk);
      flush = 1'b1;
      @(negedge clk);
      check({7'h0, fill_ready}, 8'h00);
      flush = 1'b0;
      run(8'h9f, 8'h00, 2'h0);
      $display("error, depth and flush done, narrow %0d", nb);
      stall_en = 1'b1;
      repeat (30)
      begin
        i = $urandom_range(0, 15);
        m = 8'($urandom);
        if (ops[i][7:1] == 7'h62 && m[7:6] == 2'h3) m[7:6] = 2'h0;
        run(ops[i], m, 2'($urandom));
      end
      stall_en = 1'b0;
      $display("random stream done, narrow %0d", nb);
    end
    final_report;
  end

  initial
  begin
    #100000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report;
  end
endmodule // tb_data_transfer_decode_timing
